// ---- mist_irq_core.sv ----
/*
  Interrupt request flags, enables, priority vectoring and the two
  time-base dividers with their control register.
  Assumes all inputs synchronous to clk_i; event inputs are one-cycle pulses,
  the dedicated tick clock arrives as a one-cycle enable pulse.
*/
// The implementer's own choices: the placing of the registers and strobed register access.
module mist_irq_core #(
  parameter bit CMP1_PRESENT = 1'b1
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic [mist_pkg::AW-1:0]     reg_addr_i,
  input  wire logic [mist_pkg::DW-1:0]     reg_wdata_i,
  input  wire logic                        reg_wr_i,
  input  wire logic                        reg_rd_i,
  output logic      [mist_pkg::DW-1:0]     reg_rdata_o,
  input  wire logic [1:0]                  cmp_out_i,
  input  wire logic                        usb_ep_access_i,
  input  wire logic [mist_pkg::NTM-1:0]    timer_evt_i,
  input  wire logic                        conv_done_i,
  input  wire logic                        low_supply_i,
  input  wire logic                        serial_byte_i,
  input  wire logic                        i2c_addr_match_i,
  input  wire logic                        i2c_timeout_i,
  input  wire logic                        spi_byte_i,
  input  wire logic                        tick_clk_en_i,
  input  wire logic                        stack_full_i,
  input  wire logic                        irq_ack_i,
  input  wire logic                        ret_irq_i,
  output logic                             irq_req_o,
  output logic      [3:0]                  vector_o,
  output logic                             wake_o,
  output logic                             slow_xtal_low_power_o
);

  localparam int NV = mist_pkg::NVEC;
  localparam int NS = mist_pkg::NSRC;

  logic [7:0]            tctl_q;
  logic                  global_irq_enable_q;
  logic [NV-1:0]         en_q;
  logic [NV-1:0]         flag_q;
  logic [NV-1:0]         set_ev;
  logic [NV-1:0]         pend;
  logic [NV-1:0]         wr_flag_en;
  logic [NV-1:0]         wr_en_en;
  logic [15:0]           wr_wide;
  logic [NS-1:0]         src_en_q;
  logic [NS-1:0]         src_flag_q;
  logic [NS-1:0]         src_set;
  logic [NS-1:0]         src_act_q;
  logic [NS-1:0]         src_rise;
  logic [NS-1:0]         src_prev_q;
  logic [NS-1:0]         src_flag_d;
  logic [NS-1:0]         src_en_d;
  logic [15:0]           swr_wide;
  logic [NS-1:0]         swr_flag_en;
  logic [NS-1:0]         swr_en_en;
  logic [4:0]            mf_set;
  logic [1:0]            cmp_prev_q;
  logic                  low_prev_q;
  logic [NV-1:0]         flag_prev_q;
  logic                  svc;
  logic [1:0]            sysdiv_q;
  logic                  tb_tick;
  logic [mist_pkg::TB_W-1:0] tb_cnt_q;
  logic [mist_pkg::TB_W-1:0] tb0_mask;
  logic [mist_pkg::TB_W-1:0] tb1_mask;
  logic                  tb0_ovf;
  logic                  tb1_ovf;
  logic [15:0]           en_wide;
  logic [15:0]           flag_wide;
  logic [15:0]           sen_wide;
  logic [15:0]           sfl_wide;

  assign svc = irq_ack_i && irq_req_o;
  assign slow_xtal_low_power_o = tctl_q[mist_pkg::TCTL_LP];

  // Control register
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tctl_q <= mist_pkg::TCTL_RST;
    else if (reg_wr_i && reg_addr_i == mist_pkg::A_TCTL)
      tctl_q <= reg_wdata_i;
  end

  // Global enable: service clears, return-from-interrupt sets
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      global_irq_enable_q <= 1'b0;
    else if (svc)
      global_irq_enable_q <= 1'b0;
    else if (ret_irq_i)
      global_irq_enable_q <= 1'b1;
    else if (reg_wr_i && reg_addr_i == mist_pkg::A_GIE)
      global_irq_enable_q <= reg_wdata_i[0];
  end

  // Time-base clock: dedicated enable or system clock over four
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sysdiv_q <= 2'h0;
    else
      sysdiv_q <= sysdiv_q + 2'h1;
  end

  assign tb_tick = tctl_q[mist_pkg::TCTL_CK] ? (sysdiv_q == mist_pkg::SYSDIV_LAST)
                                           : tick_clk_en_i;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tb_cnt_q <= '0;
    else if (!tctl_q[mist_pkg::TCTL_ON])
      tb_cnt_q <= '0;
    else if (tb_tick)
      tb_cnt_q <= tb_cnt_q + 15'h0001;
  end

  assign tb0_mask = (mist_pkg::TB0_BASE << tctl_q[2:0]) | mist_pkg::TB0_BASE;
  assign tb1_mask = (mist_pkg::TB1_BASE << tctl_q[5:4]) | mist_pkg::TB1_BASE;
  assign tb0_ovf = tctl_q[mist_pkg::TCTL_ON] && tb_tick && ((tb_cnt_q & tb0_mask) == tb0_mask);
  assign tb1_ovf = tctl_q[mist_pkg::TCTL_ON] && tb_tick && ((tb_cnt_q & tb1_mask) == tb1_mask);

  // Edge memory for comparators and supply detector
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmp_prev_q <= 2'h0;
      low_prev_q <= 1'b0;
    end
    else
    begin
      cmp_prev_q <= cmp_out_i;
      low_prev_q <= low_supply_i;
    end
  end

  // Source flags of the multi-function groups
  always_comb
  begin
    src_set = '0;
    src_set[mist_pkg::NTM-1:0] = timer_evt_i;
    src_set[mist_pkg::S_CONV] = conv_done_i;
    src_set[mist_pkg::S_LOW] = low_supply_i && !low_prev_q;
  end

  assign swr_wide = {reg_wdata_i, reg_wdata_i};
  assign swr_flag_en = {{2{reg_wr_i && reg_addr_i == mist_pkg::A_SFL_HI}},
                        {8{reg_wr_i && reg_addr_i == mist_pkg::A_SFL_LO}}};
  assign swr_en_en = {{2{reg_wr_i && reg_addr_i == mist_pkg::A_SEN_HI}},
                      {8{reg_wr_i && reg_addr_i == mist_pkg::A_SEN_LO}}};

  // Byte-wise write merge: a byte write leaves the other byte alone, set wins
  always_comb
  begin
    src_flag_d = (src_flag_q & ~swr_flag_en) | (swr_wide[NS-1:0] & swr_flag_en) | src_set;
    src_en_d = (src_en_q & ~swr_en_en) | (swr_wide[NS-1:0] & swr_en_en);
  end

  // Service never touches source flags; software clears them, set wins
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      src_flag_q <= '0;
      src_en_q <= '0;
      src_act_q <= '0;
    end
    else
    begin
      src_flag_q <= src_flag_d;
      src_en_q <= src_en_d;
      src_act_q <= src_flag_q & src_en_q;
    end
  end

  // Each timer pair feeds one group, conversion and supply feed the last
  assign src_rise = src_flag_q & src_en_q & ~src_act_q;
  always_comb
  begin
    mf_set = '0;
    for (int i = 0; i < mist_pkg::NTM; i++)
      mf_set[i/2] = mf_set[i/2] | src_rise[i];
    mf_set[4] = src_rise[mist_pkg::S_CONV] | src_rise[mist_pkg::S_LOW];
  end

  // Hardware set events per vector
  always_comb
  begin
    set_ev = '0;
    set_ev[mist_pkg::V_CMP0] = cmp_out_i[0] != cmp_prev_q[0];
    set_ev[mist_pkg::V_CMP1] = cmp_out_i[1] != cmp_prev_q[1];
    set_ev[mist_pkg::V_USB] = usb_ep_access_i;
    set_ev[mist_pkg::V_MF4:mist_pkg::V_MF0] = mf_set;
    set_ev[mist_pkg::V_TICK0] = tb0_ovf;
    set_ev[mist_pkg::V_TICK1] = tb1_ovf;
    set_ev[mist_pkg::V_SER] = serial_byte_i | i2c_addr_match_i | i2c_timeout_i;
    set_ev[mist_pkg::V_SPI] = spi_byte_i;
  end

  assign wr_wide = {reg_wdata_i, reg_wdata_i};
  assign wr_flag_en = {{4{reg_wr_i && reg_addr_i == mist_pkg::A_FLG_HI}},
                       {8{reg_wr_i && reg_addr_i == mist_pkg::A_FLG_LO}}};
  assign wr_en_en = {{4{reg_wr_i && reg_addr_i == mist_pkg::A_EN_HI}},
                     {8{reg_wr_i && reg_addr_i == mist_pkg::A_EN_LO}}};

  // One flag and enable per vector
  for (genvar g = 0; g < NV; g++)
  begin : g_vec
    if (g == 1 && !CMP1_PRESENT)
    begin : g_absent
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          flag_q[g] <= 1'b0;
          en_q[g] <= 1'b0;
        end
        else
        begin
          flag_q[g] <= 1'b0;
          en_q[g] <= 1'b0;
        end
      end
    end
    else
    begin : g_present
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          en_q[g] <= 1'b0;
        else if (wr_en_en[g])
          en_q[g] <= wr_wide[g];
      end
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          flag_q[g] <= 1'b0;
        else if (set_ev[g])
          flag_q[g] <= 1'b1;
        else if (svc && vector_o == 4'(g))
          flag_q[g] <= 1'b0;
        else if (wr_flag_en[g])
          flag_q[g] <= wr_wide[g];
      end
    end
  end

  // Fixed priority, lowest vector number first
  assign pend = flag_q & en_q;
  assign irq_req_o = global_irq_enable_q && !stack_full_i && (|pend);
  always_comb
  begin
    vector_o = 4'h0;
    for (int i = NV - 1; i >= 0; i--)
      if (pend[i])
        vector_o = 4'(i);
  end

  // Wake on any flag rising, enables ignored
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flag_prev_q <= '0;
    else
      flag_prev_q <= flag_q;
  end

  // Source flag history, so a disabled source wakes only on its rise
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      src_prev_q <= '0;
    else
      src_prev_q <= src_flag_q;
  end
  assign wake_o = |(flag_q & ~flag_prev_q) ||
                  |(src_flag_q & ~src_prev_q & ~src_en_q);

  // Register readback, one cycle after the strobe
  assign en_wide = {4'h0, en_q};
  assign flag_wide = {4'h0, flag_q};
  assign sen_wide = {6'h00, src_en_q};
  assign sfl_wide = {6'h00, src_flag_q};
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= '0;
    else if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        mist_pkg::A_TCTL: reg_rdata_o <= tctl_q;
        mist_pkg::A_GIE: reg_rdata_o <= {7'h00, global_irq_enable_q};
        mist_pkg::A_EN_LO: reg_rdata_o <= en_wide[7:0];
        mist_pkg::A_EN_HI: reg_rdata_o <= en_wide[15:8];
        mist_pkg::A_FLG_LO: reg_rdata_o <= flag_wide[7:0];
        mist_pkg::A_FLG_HI: reg_rdata_o <= flag_wide[15:8];
        mist_pkg::A_SEN_LO: reg_rdata_o <= sen_wide[7:0];
        mist_pkg::A_SEN_HI: reg_rdata_o <= sen_wide[15:8];
        mist_pkg::A_SFL_LO: reg_rdata_o <= sfl_wide[7:0];
        mist_pkg::A_SFL_HI: reg_rdata_o <= sfl_wide[15:8];
        default: reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  vec_gate_a: assert property (irq_req_o |-> global_irq_enable_q && !stack_full_i)
    else $error("request without global enable or with full stack");
  svc_gie_a: assert property (svc && !ret_irq_i |=> !global_irq_enable_q)
    else $error("service left global enable set");
  usb_clr_a: assert property (svc && vector_o == mist_pkg::V_USB && !usb_ep_access_i
                              |=> !flag_q[mist_pkg::V_USB])
    else $error("usb flag not cleared by service");
  cmp_set_a: assert property (cmp_out_i[0] != cmp_prev_q[0] |=> flag_q[mist_pkg::V_CMP0])
    else $error("comparator change did not set flag");
  conv_keep_a: assert property (svc && src_flag_q[mist_pkg::S_CONV] && !reg_wr_i
                                |=> src_flag_q[mist_pkg::S_CONV])
    else $error("service cleared conversion flag");
  tick_set_a: assert property (tb0_ovf |=> flag_q[mist_pkg::V_TICK0])
    else $error("tick 0 overflow lost");
  return_gie_a: assert property (ret_irq_i && !svc |=> global_irq_enable_q)
    else $error("return did not set global enable");
  wake_rise_a: assert property ($rose(flag_q[mist_pkg::V_SPI]) |-> wake_o)
    else $error("flag rise without wake");
  cmp1_gone_a: assert property (!CMP1_PRESENT |-> !flag_q[mist_pkg::V_CMP1])
    else $error("comparator 1 flag in reduced variant");
  prio_order_a: assert property (irq_req_o && pend[0] |-> vector_o == mist_pkg::V_CMP0)
    else $error("priority order broken");
  tb_off_a: assert property (!tctl_q[mist_pkg::TCTL_ON] |=> tb_cnt_q == '0 && !tb0_ovf)
    else $error("divider runs while off");
  flag_hold_a: assert property (flag_q[mist_pkg::V_SER] && !svc && !wr_flag_en[mist_pkg::V_SER]
                                |=> flag_q[mist_pkg::V_SER])
    else $error("flag dropped without cause");

  // Set paths
  cmp1_set_a: assert property (CMP1_PRESENT && cmp_out_i[1] != cmp_prev_q[1]
                               |=> flag_q[mist_pkg::V_CMP1])
    else $error("comparator 1 change did not set flag");
  usb_set_a: assert property (usb_ep_access_i |=> flag_q[mist_pkg::V_USB])
    else $error("endpoint access did not set usb flag");
  mf_set_a: assert property (mf_set[0] |=> flag_q[mist_pkg::V_MF0])
    else $error("group 0 flag not set by source");
  ser_set_a: assert property (serial_byte_i || i2c_addr_match_i || i2c_timeout_i
                              |=> flag_q[mist_pkg::V_SER])
    else $error("serial event did not set flag");
  spi_set_a: assert property (spi_byte_i |=> flag_q[mist_pkg::V_SPI])
    else $error("spi byte did not set flag");
  tick1_set_a: assert property (tb1_ovf |=> flag_q[mist_pkg::V_TICK1])
    else $error("tick 1 overflow lost");

  // Clear paths and gating
  usb_gate_a: assert property (irq_req_o && vector_o == mist_pkg::V_USB
                               |-> en_q[mist_pkg::V_USB])
    else $error("usb vector without usb enable");
  mf_clr_a: assert property (svc && vector_o == mist_pkg::V_MF0 && !mf_set[0]
                             |=> !flag_q[mist_pkg::V_MF0])
    else $error("group 0 flag not cleared by service");
  ser_clr_a: assert property (svc && vector_o == mist_pkg::V_SER && !set_ev[mist_pkg::V_SER]
                              |=> !flag_q[mist_pkg::V_SER])
    else $error("serial flag not cleared by service");
  low_keep_a: assert property (svc && src_flag_q[mist_pkg::S_LOW] && !reg_wr_i
                               |=> src_flag_q[mist_pkg::S_LOW])
    else $error("service cleared supply flag");
  gie_low_a: assert property (!global_irq_enable_q |-> !irq_req_o)
    else $error("request with global enable clear");
  stack_hold_a: assert property (stack_full_i |-> !irq_req_o)
    else $error("request with stack full");

  svc_usb_c: cover property (svc && vector_o == mist_pkg::V_USB);
  svc_mf4_c: cover property (svc && vector_o == mist_pkg::V_MF4);
  tick1_c: cover property (tb1_ovf);
  stack_hold_c: cover property (stack_full_i && |pend && global_irq_enable_q);
  src_wake_c: cover property (wake_o && !(|(flag_q & ~flag_prev_q)));

endmodule : mist_irq_core

// ---- mist_pkg.sv ----
/*
  Constants of the interrupt source and time-base block: register indices,
  reset values, vector numbers and divider figures.
  Assumes an 8-bit register port and a single system clock.
*/
package mist_pkg;
  localparam int AW = 4;
  localparam int DW = 8;
  localparam int NVEC = 12;
  localparam int NSRC = 10;
  localparam int NTM = 8;
  // Register indices
  localparam logic [3:0] A_TCTL = 4'h0;
  localparam logic [3:0] A_GIE = 4'h1;
  localparam logic [3:0] A_EN_LO = 4'h2;
  localparam logic [3:0] A_EN_HI = 4'h3;
  localparam logic [3:0] A_FLG_LO = 4'h4;
  localparam logic [3:0] A_FLG_HI = 4'h5;
  localparam logic [3:0] A_SEN_LO = 4'h6;
  localparam logic [3:0] A_SEN_HI = 4'h7;
  localparam logic [3:0] A_SFL_LO = 4'h8;
  localparam logic [3:0] A_SFL_HI = 4'h9;
  localparam logic [7:0] TCTL_RST = 8'h37;
  // Control register fields
  localparam int TCTL_ON = 7;
  localparam int TCTL_CK = 6;
  localparam int TCTL_LP = 3;
  localparam int TCTL_P1 = 4;
  localparam int TCTL_P0 = 0;
  // Vector numbers, lowest number has highest priority
  localparam logic [3:0] V_CMP0 = 4'h0;
  localparam logic [3:0] V_CMP1 = 4'h1;
  localparam logic [3:0] V_USB = 4'h2;
  localparam logic [3:0] V_MF0 = 4'h3;
  localparam logic [3:0] V_MF4 = 4'h7;
  localparam logic [3:0] V_TICK0 = 4'h8;
  localparam logic [3:0] V_TICK1 = 4'h9;
  localparam logic [3:0] V_SER = 4'ha;
  localparam logic [3:0] V_SPI = 4'hb;
  // Source indices inside the multi-function groups
  localparam int S_CONV = 8;
  localparam int S_LOW = 9;
  // Time base
  localparam int TB_W = 15;
  localparam logic [TB_W-1:0] TB0_BASE = 15'h00ff;
  localparam logic [TB_W-1:0] TB1_BASE = 15'h0fff;
  localparam logic [1:0] SYSDIV_LAST = 2'h3;
endpackage : mist_pkg

// ---- placeholder_none.sv ----
/*
  Intentionally empty compilation unit.
  Assumes nothing.
*/

// ---- tb_top.sv ----
/*
  Self-checking bench for the interrupt source and time-base core.
  Assumes the default comparator count and one 10 MHz system clock.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     clk_i;
  logic                     rst_n_i;
  logic [mist_pkg::AW-1:0]  reg_addr_i;
  logic [mist_pkg::DW-1:0]  reg_wdata_i;
  logic                     reg_wr_i;
  logic                     reg_rd_i;
  logic [mist_pkg::DW-1:0]  reg_rdata_o;
  logic [1:0]               cmp_out_i;
  logic                     usb_ep_access_i;
  logic [mist_pkg::NTM-1:0] timer_evt_i;
  logic                     conv_done_i;
  logic                     low_supply_i;
  logic                     serial_byte_i;
  logic                     i2c_addr_match_i;
  logic                     i2c_timeout_i;
  logic                     spi_byte_i;
  logic                     tick_clk_en_i;
  logic                     stack_full_i;
  logic                     irq_ack_i;
  logic                     ret_irq_i;
  logic                     red_irq;
  logic                     irq_req_o;
  logic [3:0]               vector_o;
  logic                     wake_o;
  logic                     slow_xtal_low_power_o;
  int                       miscompares;
  int                       check_count;
  int                       cyc;
  int                       wake_cnt;

  mist_irq_core dut (.clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .cmp_out_i, .usb_ep_access_i, .timer_evt_i, .conv_done_i, .low_supply_i,
    .serial_byte_i, .i2c_addr_match_i, .i2c_timeout_i, .spi_byte_i, .tick_clk_en_i,
    .stack_full_i, .irq_ack_i, .ret_irq_i, .irq_req_o, .vector_o, .wake_o,
    .slow_xtal_low_power_o);

  // Reduced variant on the same stimulus: comparator 1 must never request
  mist_irq_core #(.CMP1_PRESENT(1'b0)) dut_red (.clk_i, .rst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o(), .cmp_out_i, .usb_ep_access_i,
    .timer_evt_i, .conv_done_i, .low_supply_i, .serial_byte_i, .i2c_addr_match_i,
    .i2c_timeout_i, .spi_byte_i, .tick_clk_en_i, .stack_full_i, .irq_ack_i, .ret_irq_i,
    .irq_req_o(red_irq), .vector_o(), .wake_o(), .slow_xtal_low_power_o());

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // Dedicated tick clock: one enable pulse every second system cycle
  always @(posedge clk_i) tick_clk_en_i <= ~tick_clk_en_i;
  always @(negedge clk_i) if (wake_o === 1'b1) wake_cnt++;

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string name);
    @(posedge clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    chk(name, reg_rdata_o, exp);
  endtask : rchk

  task automatic pulse(input int k);
    @(posedge clk_i);
    case (k)
      0: usb_ep_access_i <= 1'b1;
      1: serial_byte_i <= 1'b1;
      2: i2c_addr_match_i <= 1'b1;
      3: i2c_timeout_i <= 1'b1;
      4: spi_byte_i <= 1'b1;
      5: conv_done_i <= 1'b1;
      default: timer_evt_i <= 8'h02;
    endcase
    @(posedge clk_i);
    {usb_ep_access_i, serial_byte_i, i2c_addr_match_i, i2c_timeout_i} <= 4'h0;
    {spi_byte_i, conv_done_i} <= 2'h0;
    timer_evt_i <= 8'h00;
  endtask : pulse

  // Expects vector v pending, takes it, then returns from it
  task automatic service(input logic [3:0] v);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    chk("irq_req_o", irq_req_o, 1'b1);
    chk("vector_o", vector_o, v);
    @(posedge clk_i);
    irq_ack_i <= 1'b1;
    @(posedge clk_i);
    irq_ack_i <= 1'b0;
    @(negedge clk_i);
    chk("irq_req_o after ack", irq_req_o, 1'b0);
    rchk(mist_pkg::A_GIE, 8'h00, "global enable after ack");
    @(posedge clk_i);
    ret_irq_i <= 1'b1;
    @(posedge clk_i);
    ret_irq_i <= 1'b0;
    rchk(mist_pkg::A_GIE, 8'h01, "global enable after return");
  endtask : service

  task automatic t_regs();
    rchk(mist_pkg::A_TCTL, 8'h37, "control reset");
    chk("low power out", slow_xtal_low_power_o, 1'b0);
    wr(mist_pkg::A_TCTL, 8'h08);
    @(negedge clk_i);
    chk("low power out", slow_xtal_low_power_o, 1'b1);
    rchk(mist_pkg::A_TCTL, 8'h08, "control readback");
    rchk(4'hf, 8'h00, "unmapped read");
  endtask : t_regs

  task automatic t_cmp_usb();
    wr(mist_pkg::A_GIE, 8'h01);
    wr(mist_pkg::A_EN_LO, 8'h07);
    stack_full_i <= 1'b1;
    cmp_out_i    <= 2'b01;
    pulse(0);
    repeat (2) @(negedge clk_i);
    chk("irq_req_o stack full", irq_req_o, 1'b0);
    rchk(mist_pkg::A_FLG_LO, 8'h05, "vector flags");
    @(posedge clk_i);
    stack_full_i <= 1'b0;
    service(mist_pkg::V_CMP0);
    service(mist_pkg::V_USB);
    rchk(mist_pkg::A_FLG_LO, 8'h00, "vector flags after service");
    @(posedge clk_i);
    cmp_out_i <= 2'b11;
    repeat (2) @(negedge clk_i);
    chk("reduced variant request", red_irq, 1'b0);
    service(mist_pkg::V_CMP1);
    wr(mist_pkg::A_EN_LO, 8'h00);
    wake_cnt = 0;
    cmp_out_i <= 2'b10;
    repeat (4) @(negedge clk_i);
    chk("wake pulses", 16'(wake_cnt), 16'h0001);
    chk("irq_req_o disabled", irq_req_o, 1'b0);
    wr(mist_pkg::A_EN_LO, 8'h01);
    service(mist_pkg::V_CMP0);
  endtask : t_cmp_usb

  task automatic t_multi();
    wr(mist_pkg::A_EN_LO, 8'h88);
    wr(mist_pkg::A_SEN_LO, 8'h02);
    wr(mist_pkg::A_SEN_HI, 8'h03);
    pulse(6);
    service(mist_pkg::V_MF0);
    rchk(mist_pkg::A_SFL_LO, 8'h02, "timer source flags");
    rchk(mist_pkg::A_FLG_LO, 8'h00, "group flags");
    pulse(5);
    service(mist_pkg::V_MF4);
    @(posedge clk_i);
    low_supply_i <= 1'b1;
    @(posedge clk_i);
    service(mist_pkg::V_MF4);
    rchk(mist_pkg::A_SFL_HI, 8'h03, "conversion and supply flags");
    wr(mist_pkg::A_SFL_LO, 8'h00);
    wr(mist_pkg::A_SFL_HI, 8'h00);
    wr(mist_pkg::A_EN_LO, 8'h00);
  endtask : t_multi

  task automatic t_serial();
    wr(mist_pkg::A_EN_HI, 8'h0c);
    for (int k = 1; k <= 3; k++)
    begin
      pulse(k);
      service(mist_pkg::V_SER);
    end
    pulse(4);
    service(mist_pkg::V_SPI);
    rchk(mist_pkg::A_FLG_HI, 8'h00, "serial flags");
  endtask : t_serial

  // Measures the spacing of two tick requests in system cycles
  task automatic tick(input logic [7:0] ctrl, input logic [7:0] en, input int per);
    int t0;
    wr(mist_pkg::A_TCTL, 8'h00);
    wr(mist_pkg::A_EN_HI, en);
    wr(mist_pkg::A_FLG_HI, 8'h00);
    wr(mist_pkg::A_TCTL, ctrl);
    for (int n = 0; irq_req_o !== 1'b1 && n < ((per == 0) ? 2000 : 40000); n++)
      @(negedge clk_i);
    if (per == 0)
    begin
      chk("tick while off", irq_req_o, 1'b0);
      return;
    end
    t0 = cyc;
    service(en[0] ? mist_pkg::V_TICK0 : mist_pkg::V_TICK1);
    for (int n = 0; irq_req_o !== 1'b1 && n < 40000; n++) @(negedge clk_i);
    chk("tick period", 16'(cyc - t0), 16'(per));
  endtask : tick

  initial
  begin
    {rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
    {cmp_out_i, usb_ep_access_i, timer_evt_i, conv_done_i, low_supply_i} = '0;
    {serial_byte_i, i2c_addr_match_i, i2c_timeout_i, spi_byte_i} = '0;
    {tick_clk_en_i, stack_full_i, irq_ack_i, ret_irq_i} = '0;
    {miscompares, check_count, cyc, wake_cnt} = '0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_cmp_usb();
    t_multi();
    t_serial();
    tick(8'hc0, 8'h01, 1024);
    tick(8'hc2, 8'h01, 4096);
    tick(8'h80, 8'h01, 512);
    tick(8'hc0, 8'h02, 16384);
    tick(8'h40, 8'h01, 0);
    report_and_stop();
  end
endmodule : tb_top
